// File: tb/dtec_pin_src.sv
// Pulse source standing in for the external timer input pins
module dtec_pin_src (
  input wire logic pclk,
  output logic pin0,
  output logic pin1
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle low; each pulse gives one rising and one falling edge
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
  end

  // Edges spaced w cycles apart so the synchroniser sees each one
  task automatic pulse(input logic idx, input int w);
    repeat (2) begin
      repeat (w) @(posedge pclk);
      if (idx) begin
        pin1 <= !pin1;
      end else begin
        pin0 <= !pin0;
      end
    end
    repeat (w) @(posedge pclk);
  endtask
endmodule

// File: tb/dtec_top_test.sv
// Register-level test of the dual timer/event counter
module dtec_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, power_down, pin0, pin1, pready;
  logic pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cap;
  logic [1:0] timer_overflow;
  logic [15:0] v, w;
  int n_fail = 0;
  int cmp_count = 0;
  int n_ovf0 = 0;
  int n_ovf1 = 0;
  int lo;

  always #5 pclk = ~pclk;

  dtec_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down(power_down), .timer0_input_pin(pin0),
    .timer1_input_pin(pin1), .timer_overflow(timer_overflow));

  dtec_pin_src src (.pclk(pclk), .pin0(pin0), .pin1(pin1));

  // Overflow pulses counted per timer
  always @(posedge pclk) begin
    if (timer_overflow[0] === 1'b1) n_ovf0++;
    if (timer_overflow[1] === 1'b1) n_ovf1++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] addr_of(input logic t, input logic [3:0] o);
    return {7'h00, t, o};
  endfunction

  // One APB transfer; the leading edge keeps release and setup apart
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("Error at %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr16(input logic t, input logic [15:0] val);
    apb(1'b1, addr_of(t, dtec_pkg::OFS_COUNT_LOW), 32'(val[7:0]));
    apb(1'b1, addr_of(t, dtec_pkg::OFS_COUNT_HIGH), 32'(val[15:8]));
  endtask

  task automatic rd16(input logic t, output logic [15:0] q);
    apb(1'b0, addr_of(t, dtec_pkg::OFS_COUNT_HIGH), 32'h0000_0000);
    q[15:8] = rd[7:0];
    apb(1'b0, addr_of(t, dtec_pkg::OFS_COUNT_LOW), 32'h0000_0000);
    q[7:0] = rd[7:0];
  endtask

  task automatic ctl(input logic t, input logic [7:0] c);
    apb(1'b1, addr_of(t, dtec_pkg::OFS_CONTROL), 32'(c));
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the slow-clock scenario
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    $display("Error at %0t: run timed out", $time);
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, power_down} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state and an unmapped access
    apb(1'b0, addr_of(1'b0, dtec_pkg::OFS_CONTROL), 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000);
    // Stopped counter: buffered low byte, committed by high byte
    wr16(1'b0, 16'h1234);
    rd16(1'b0, v);
    check(32'(v), 32'h0000_1234);
    apb(1'b1, addr_of(1'b0, dtec_pkg::OFS_COUNT_LOW), 32'h0000_0077);
    rd16(1'b0, v);
    check(32'(v), 32'h0000_1234);
    apb(1'b1, addr_of(1'b0, dtec_pkg::OFS_COUNT_HIGH), 32'h0000_0056);
    rd16(1'b0, v);
    check(32'(v), 32'h0000_5677);
    // Timer 0 internal tick, with slack for bus overhead
    wr16(1'b0, 16'h0000);
    ctl(1'b0, 8'h90);
    repeat (400) @(posedge pclk);
    ctl(1'b0, 8'h80);
    rd16(1'b0, v);
    lo = 400 / dtec_pkg::FAST_DIV;
    check(32'(v >= lo - 1 && v <= lo + 4), 32'h0000_0001);
    // Low byte read returns the capture, not the live count
    ctl(1'b0, 8'h90);
    apb(1'b0, addr_of(1'b0, dtec_pkg::OFS_COUNT_HIGH), 32'h0000_0000);
    repeat (40) @(posedge pclk);
    apb(1'b0, addr_of(1'b0, dtec_pkg::OFS_COUNT_LOW), 32'h0000_0000);
    cap = rd;
    repeat (40) @(posedge pclk);
    apb(1'b0, addr_of(1'b0, dtec_pkg::OFS_COUNT_LOW), 32'h0000_0000);
    check(rd, cap);
    // Pulse width: start on rising, stop on falling, run bit cleared
    ctl(1'b0, 8'hC8);
    wr16(1'b0, 16'h0000);
    ctl(1'b0, 8'hD8);
    src.pulse(1'b0, 80);
    rd16(1'b0, v);
    check(32'(v >= 18 && v <= 22), 32'h0000_0001);
    apb(1'b0, addr_of(1'b0, dtec_pkg::OFS_CONTROL), 32'h0000_0000);
    check(rd, 32'h0000_00C8);
    src.pulse(1'b0, 40);
    rd16(1'b0, w);
    check(32'(w), 32'(v));
    // Timer 1 slow tick over ten periods
    ctl(1'b1, 8'h80);
    wr16(1'b1, 16'h0000);
    ctl(1'b1, 8'h90);
    repeat (10 * dtec_pkg::SLOW_DIV) @(posedge pclk);
    ctl(1'b1, 8'h80);
    rd16(1'b1, v);
    check(32'(v >= 9 && v <= 11), 32'h0000_0001);
    // Rising-edge event count across an overflow
    ctl(1'b1, 8'h40);
    wr16(1'b1, 16'hFFFE);
    ctl(1'b1, 8'h50);
    repeat (3) src.pulse(1'b1, 6);
    rd16(1'b1, v);
    check(32'(v), 32'h0000_FFFF);
    check(32'(n_ovf1), 32'h0000_0001);
    // Falling edges in power-down; preload waits for the overflow
    ctl(1'b1, 8'h58);
    power_down <= 1'b1;
    wr16(1'b1, 16'h0100);
    rd16(1'b1, v);
    check(32'(v), 32'h0000_FFFF);
    src.pulse(1'b1, 6);
    rd16(1'b1, v);
    check(32'(v), 32'h0000_0100);
    check(32'(n_ovf1), 32'h0000_0002);
    check(32'(n_ovf0), 32'h0000_0000);
    power_down <= 1'b0;
    give_verdict();
  end
endmodule

// File: verilog/dtec_pkg.sv
// Constants, types and helpers shared by the dual timer/event counter
package dtec_pkg;

  // Clock rates and derived count-clock dividers
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int FAST_DIV = 4;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int SLOW_DIV = (SYS_CLK_HZ + SLOW_CLK_HZ - 1) / SLOW_CLK_HZ;
  localparam int SLOW_CNT_W = 12;

  // Register map: one block of three words per timer
  localparam logic [11:0] OFS_TIMER0 = 12'h000;
  localparam logic [11:0] OFS_TIMER1 = 12'h010;
  localparam logic [3:0] OFS_COUNT_LOW = 4'h0;
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;

  // Control register field positions
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_RUN = 4;
  localparam int CTRL_EDGE = 3;

  // Reset values and the full-scale count
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PRELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_EVENT,
    MODE_TIMER,
    MODE_PULSE
  } dtec_mode_e;

  typedef enum logic [1:0] {
    REG_LOW,
    REG_HIGH,
    REG_CTRL,
    REG_NONE
  } dtec_reg_e;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] preload;
    logic [7:0] wbuf;
    logic [7:0] rbuf;
    dtec_mode_e mode;
    logic run;
    logic edge_sel;
    logic started;
  } dtec_tmr_s;

  typedef struct packed {
    logic hit;
    logic idx;
    dtec_reg_e reg_id;
  } dtec_dec_s;

  // Address decode, shared by the bus answer and the register updates
  function automatic dtec_dec_s dtec_decode(input logic [11:0] addr);
    dtec_dec_s d;
    logic [11:0] base;
    d = '{hit: 1'b0, idx: 1'b0, reg_id: REG_NONE};
    base = {addr[11:4], 4'h0};
    if (base == OFS_TIMER0 || base == OFS_TIMER1) begin
      d.idx = (base == OFS_TIMER1);
      if (addr[3:0] == OFS_COUNT_LOW) begin
        d.reg_id = REG_LOW;
      end else if (addr[3:0] == OFS_COUNT_HIGH) begin
        d.reg_id = REG_HIGH;
      end else if (addr[3:0] == OFS_CONTROL) begin
        d.reg_id = REG_CTRL;
      end
      d.hit = (d.reg_id != REG_NONE);
    end
    return d;
  endfunction

endpackage

// File: verilog/dtec_top.sv
// Dual 16-bit timer/event counter with an APB register slave
//
// Notes on behaviour
// R1: Two independent 16-bit up counters: timer, event or pulse width modes.
// R2: Timer zero internal clock is the system clock divided by four.
// R3: Timer one internal clock is the 32768Hz clock.
// R4: Timer and pulse modes use internal clock; event mode uses the pin.
// R5: Event mode adds exactly one per selected pin transition.
// R6: On overflow past full scale: request pulse, reload preload, keep counting.
// R7: Preload content is undefined until software writes it.
// R8: Preload write while stopped also copies into the counter at once.
// R9: Preload write while running reaches the counter at next overflow.
// R10: Low byte write goes only to a holding buffer.
// R11: High byte write stores high byte and moves held low byte along.
// R12: Software writes the low byte before the high byte.
// R13: High byte read captures live low byte; software reads high first.
// R14: Low byte read returns the captured buffer, not the live count.
// R15: Mode field sits in control bits seven and six.
// R16: Control bit four runs the counter when one, holds it when zero.
// R17: Control bit three selects active pin transition polarity.
// R18: Mode zero-one is event counting, straight from the pin.
// R19: Event mode: edge bit zero counts rising, one counts falling.
// R20: Pulse mode counts across the pulse, then hardware clears run.
// R21: Event mode keeps counting in power-down; overflow flags wake-up.
// R22: Mode one-zero is timer, one-one is pulse; separate overflow per timer.
// R23: Pin transitions are synchronised before use, one clock of jitter.
//
// Chosen here: the placing of the registers and register access over APB.
module dtec_top #(
  parameter int NUM_TIMERS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down,
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  output logic [1:0] timer_overflow
);

  // Prescaler state
  logic [1:0] fast_cnt;
  logic [1:0] next_fast_cnt;
  logic [dtec_pkg::SLOW_CNT_W-1:0] slow_cnt;
  logic [dtec_pkg::SLOW_CNT_W-1:0] next_slow_cnt;
  logic [1:0] tick;
  logic [1:0] next_tick;

  // Pin synchronisers and edge detection
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  // Bus and timer state
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  dtec_pkg::dtec_tmr_s tmr [2];
  dtec_pkg::dtec_tmr_s next_tmr [2];
  logic [1:0] next_overflow;
  dtec_pkg::dtec_dec_s dec;
  logic bus_access;
  logic bus_done;
  logic bus_wr;
  logic bus_rd_high;

  // Count-clock enables: divide by four and the slow rate
  always_comb begin
    next_fast_cnt = fast_cnt + 2'b01;
    next_slow_cnt = slow_cnt + 12'h001;
    next_tick = 2'b00;
    if (fast_cnt == 2'(dtec_pkg::FAST_DIV - 1)) begin
      next_fast_cnt = 2'b00;
      next_tick[0] = 1'b1; // [R2]
    end
    if (slow_cnt == 12'(dtec_pkg::SLOW_DIV - 1)) begin
      next_slow_cnt = 12'h000;
      next_tick[1] = 1'b1; // [R3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt <= 2'b00;
      slow_cnt <= 12'h000;
      tick <= 2'b00;
    end else begin
      fast_cnt <= next_fast_cnt;
      slow_cnt <= next_slow_cnt;
      tick <= next_tick;
    end
  end

  // Two flops before anything looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 2'b00;
      pin_sync <= 2'b00;
      pin_prev <= 2'b00;
    end else begin
      pin_meta <= {timer1_input_pin, timer0_input_pin}; // [R23]
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Edges seen only on the second stage
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // Bus phase decode; answer is one wait state after the access phase begins
  assign dec = dtec_pkg::dtec_decode(paddr);
  assign bus_access = psel && penable;
  assign bus_done = bus_access && pready;
  assign bus_wr = bus_done && pwrite && dec.hit;
  assign bus_rd_high = bus_done && !pwrite && dec.hit &&
                       dec.reg_id == dtec_pkg::REG_HIGH;

  // Read mux; unused control bits read as zero
  always_comb begin
    next_pready = bus_access && !pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (bus_done) begin
      next_pslverr = 1'b0;
    end
    if (bus_access && !pready) begin
      next_pslverr = !dec.hit;
      next_prdata = 32'h0000_0000;
      if (!pwrite && dec.hit) begin
        case (dec.reg_id)
          dtec_pkg::REG_LOW: begin
            next_prdata[7:0] = tmr[dec.idx].rbuf; // [R14]
          end
          dtec_pkg::REG_HIGH: begin
            next_prdata[7:0] = tmr[dec.idx].count[15:8];
          end
          dtec_pkg::REG_CTRL: begin
            next_prdata[dtec_pkg::CTRL_MODE_HI:dtec_pkg::CTRL_MODE_LO] =
              tmr[dec.idx].mode;
            next_prdata[dtec_pkg::CTRL_RUN] = tmr[dec.idx].run;
            next_prdata[dtec_pkg::CTRL_EDGE] = tmr[dec.idx].edge_sel;
          end
          default: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Counter update; software writes come last so they win over hardware
  always_comb begin
    logic inc;
    logic ev_on;
    logic pw_start;
    logic pw_end;
    logic [15:0] ld;
    inc = 1'b0;
    ev_on = 1'b0;
    pw_start = 1'b0;
    pw_end = 1'b0;
    ld = 16'h0000;
    next_overflow = 2'b00;
    for (int i = 0; i < 2; i++) begin
      next_tmr[i] = tmr[i];
      ev_on = tmr[i].edge_sel ? pin_fall[i] : pin_rise[i]; // [R19] [R17]
      // Pulse mode: edge bit zero measures a low pulse
      pw_start = tmr[i].edge_sel ? pin_rise[i] : pin_fall[i];
      pw_end = tmr[i].edge_sel ? pin_fall[i] : pin_rise[i];
      case (tmr[i].mode)
        dtec_pkg::MODE_EVENT: begin
          // Runs through power-down, no prescaler
          inc = tmr[i].run && ev_on; // [R5] [R18] [R21] [R4]
        end
        dtec_pkg::MODE_TIMER: begin
          inc = tmr[i].run && tick[i] && !power_down; // [R4] [R22]
        end
        dtec_pkg::MODE_PULSE: begin
          inc = tmr[i].run && tmr[i].started && tick[i] && !power_down;
        end
        default: begin
          inc = 1'b0;
        end
      endcase
      if (inc) begin // [R16]
        if (tmr[i].count == dtec_pkg::COUNT_FULL) begin
          next_tmr[i].count = tmr[i].preload; // [R6] [R9]
          next_overflow[i] = 1'b1; // [R22]
        end else begin
          next_tmr[i].count = tmr[i].count + 16'h0001; // [R1]
        end
      end
      if (tmr[i].mode == dtec_pkg::MODE_PULSE && tmr[i].run) begin
        if (!tmr[i].started && pw_start) begin
          next_tmr[i].started = 1'b1; // [R20]
        end else if (tmr[i].started && pw_end) begin
          next_tmr[i].run = 1'b0; // [R20]
          next_tmr[i].started = 1'b0;
        end
      end
      if (!tmr[i].run) begin
        next_tmr[i].started = 1'b0;
      end
      if (bus_rd_high && dec.idx == 1'(i)) begin
        next_tmr[i].rbuf = tmr[i].count[7:0]; // [R13]
      end
      if (bus_wr && dec.idx == 1'(i)) begin
        ld = {pwdata[7:0], tmr[i].wbuf};
        case (dec.reg_id)
          dtec_pkg::REG_LOW: begin
            next_tmr[i].wbuf = pwdata[7:0]; // [R10] [R12]
          end
          dtec_pkg::REG_HIGH: begin
            next_tmr[i].preload = ld; // [R11]
            if (!tmr[i].run) begin
              next_tmr[i].count = ld; // [R8]
            end
          end
          dtec_pkg::REG_CTRL: begin
            next_tmr[i].mode = dtec_pkg::dtec_mode_e'(
              pwdata[dtec_pkg::CTRL_MODE_HI:dtec_pkg::CTRL_MODE_LO]); // [R15]
            next_tmr[i].run = pwdata[dtec_pkg::CTRL_RUN]; // [R16]
            next_tmr[i].edge_sel = pwdata[dtec_pkg::CTRL_EDGE]; // [R17]
          end
          default: begin
            next_tmr[i].wbuf = tmr[i].wbuf;
          end
        endcase
      end
    end
  end

  // Preload reset is only a defined stand-in; software must write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        tmr[i] <= '{count: dtec_pkg::COUNT_RST,
                    preload: dtec_pkg::PRELOAD_RST, // [R7]
                    wbuf: 8'h00, rbuf: 8'h00,
                    mode: dtec_pkg::MODE_NONE,
                    run: 1'b0, edge_sel: 1'b0, started: 1'b0};
      end
      timer_overflow <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        tmr[i] <= next_tmr[i];
      end
      timer_overflow <= next_overflow;
    end
  end

  // Checks on bus timing and counter behaviour
  a_bus_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    bus_access && !pready |=> pready && !$past(pready))
    else $error("ready did not follow access phase");
  a_bus_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held more than one cycle");
  a_low_write_held: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    bus_wr && dec.reg_id == dtec_pkg::REG_LOW && dec.idx == 1'b0 &&
    !tmr[0].run |=> tmr[0].count == $past(tmr[0].count))
    else $error("low byte write changed the counter");
  a_run_hold: assert property ( // [R16]
    @(posedge pclk) disable iff (!presetn)
    !tmr[0].run && !bus_wr |=> tmr[0].count == $past(tmr[0].count))
    else $error("stopped counter moved");
  a_ctrl_fields: assert property ( // [R15] [R16] [R17]
    @(posedge pclk) disable iff (!presetn)
    bus_wr && dec.reg_id == dtec_pkg::REG_CTRL && dec.idx == 1'b0
    |=> tmr[0].mode == $past(pwdata[7:6]) &&
        tmr[0].run == $past(pwdata[dtec_pkg::CTRL_RUN]) &&
        tmr[0].edge_sel == $past(pwdata[dtec_pkg::CTRL_EDGE]))
    else $error("control write fields not stored");
  a_high_write_stop: assert property ( // [R8]
    @(posedge pclk) disable iff (!presetn)
    bus_wr && dec.reg_id == dtec_pkg::REG_HIGH && dec.idx == 1'b0 &&
    !tmr[0].run
    |=> tmr[0].count == {$past(pwdata[7:0]), $past(tmr[0].wbuf)})
    else $error("stopped preload not copied to counter");
  a_high_write_run: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    bus_wr && dec.reg_id == dtec_pkg::REG_HIGH && dec.idx == 1'b1 &&
    tmr[1].run && !next_overflow[1]
    |=> tmr[1].preload == {$past(pwdata[7:0]), $past(tmr[1].wbuf)} &&
        (tmr[1].count == $past(tmr[1].count) ||
         tmr[1].count == $past(tmr[1].count) + 16'h0001))
    else $error("running preload write reached counter early");
  a_hi_read_cap: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    bus_rd_high && dec.idx == 1'b1
    |=> tmr[1].rbuf == $past(tmr[1].count[7:0]))
    else $error("high byte read did not capture low byte");
  a_ovf_reload: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    timer_overflow[1] |-> tmr[1].count == $past(tmr[1].preload))
    else $error("overflow did not reload preload");
  a_evt_step: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    tmr[1].mode == dtec_pkg::MODE_EVENT && tmr[1].run &&
    !tmr[1].edge_sel && pin_rise[1] && !bus_wr &&
    tmr[1].count != dtec_pkg::COUNT_FULL
    |=> tmr[1].count == $past(tmr[1].count) + 16'h0001)
    else $error("event did not advance counter by one");
  a_slow_tick: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    tick[1] |-> slow_cnt == 12'h000)
    else $error("slow count clock out of step");
  a_fast_tick: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    tick[0] |=> !tick[0] [*3] ##1 tick[0])
    else $error("fast count clock not divide by four");
  a_pwm_stop: assert property ( // [R20]
    @(posedge pclk) disable iff (!presetn)
    tmr[0].mode == dtec_pkg::MODE_PULSE && tmr[0].started &&
    tmr[0].run && (tmr[0].edge_sel ? pin_fall[0] : pin_rise[0]) && !bus_wr
    |=> !tmr[0].run)
    else $error("pulse end did not clear run");
  a_pwm_start: assert property ( // [R20]
    @(posedge pclk) disable iff (!presetn)
    tmr[0].mode == dtec_pkg::MODE_PULSE && tmr[0].run && !tmr[0].started &&
    (tmr[0].edge_sel ? pin_rise[0] : pin_fall[0]) && !bus_wr
    |=> tmr[0].started)
    else $error("pulse start edge not taken");
  a_rd_low_buf: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    bus_done && !pwrite && dec.reg_id == dtec_pkg::REG_LOW
    |-> prdata == {24'h00_0000, tmr[dec.idx].rbuf})
    else $error("low byte read not from buffer");

endmodule
